//--- include/adcctl_consts.vh
// Register map, field positions and timing counts of the converter control block.
// Assumes inclusion by bare name from the design file.
`ifndef ADCCTL_CONSTS_VH
`define ADCCTL_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADCCTL_OFS_RES_LOW   8'h78
`define ADCCTL_OFS_RES_HIGH  8'h79
`define ADCCTL_OFS_CTRL      8'h7A
`define ADCCTL_OFS_CTRL2     8'h7B
`define ADCCTL_OFS_MUXCFG    8'h7C
`define ADCCTL_OFS_IRQ_MASK  8'h7D
`define ADCCTL_OFS_IRQ_STAT  8'h7E

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADCCTL_BIT_POWER     7
`define ADCCTL_BIT_LAUNCH    6
`define ADCCTL_BIT_AUTO      5
`define ADCCTL_BIT_DONE      4
`define ADCCTL_BIT_IRQ_EN    3
`define ADCCTL_BIT_LEFT      5
`define ADCCTL_RESET_VAL     8'h00

// ----------------------------------------
// Conversion lengths in converter clocks
// ----------------------------------------
`define ADCCTL_CYC_FIRST     5'h19
`define ADCCTL_CYC_NORMAL    5'h0D

// ----------------------------------------
// Prescaler terminal counts, one less than the divisor
// ----------------------------------------
`define ADCCTL_PRE_MAX_2     7'h01
`define ADCCTL_PRE_MAX_4     7'h03
`define ADCCTL_PRE_MAX_8     7'h07
`define ADCCTL_PRE_MAX_16    7'h0F
`define ADCCTL_PRE_MAX_32    7'h1F
`define ADCCTL_PRE_MAX_64    7'h3F
`define ADCCTL_PRE_MAX_128   7'h7F

`endif

//--- design/adcctl_top.v
// Control, status, prescaler and result registers of a 10-bit converter.
// Assumes a single 40 MHz clock, synchronous inputs, and an analog core that
// takes sample_start_o and delivers its code on core_result_i at completion.
//
// Behaviour
// [R1] In single mode each write of one to the launch bit starts exactly one conversion; the code drops such a write while busy_q is set.
// [R2] In free-running mode only the first conversion needs a write; later ones follow by themselves.
// [R3] The first conversion after enabling lasts 25 converter clocks, every other one 13.
// [R4] The launch bit reads one while a conversion runs and zero once it completes.
// [R5] Writing zero to the launch bit has no effect at all.
// [R6] With auto-trigger enabled a rising edge of the chosen trigger starts a conversion.
// [R7] The trigger is chosen by the trigger-source select field of the second control register.
// [R8] The done flag is set when a conversion completes and the result is stored.
// [R9] The interrupt request is high only while done flag, irq enable and global enable are all set.
// [R10] The done flag clears when the processor takes the matching interrupt vector.
// [R11] Writing one to the done flag clears it; writing zero leaves it.
// [R12] Software should not read-modify-write the control register, as that clears a pending flag.
// [R13] The divider field divides the clock by 2,2,4,8,16,32,64,128 for codes 0 to 7.
// [R14] Right-aligned, low byte holds bits 7..0 and high byte bits 9..8 with zeros above.
// [R15] Left-aligned, high byte holds bits 9..2.
// [R16] Left-aligned, low byte holds bits 1..0 at the top with zeros below.
// [R17] Clearing the power bit turns the converter off and ends any running conversion.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "adcctl_consts.vh"

module adcctl_top #(
  parameter TRIG_W = 3,
  parameter RES_W  = 10
) (
  input  wire              clk_sys_i,
  input  wire              rst_n_i,
  input  wire [7:0]        reg_addr_i,
  input  wire [7:0]        reg_wdata_i,
  input  wire              reg_wr_i,
  input  wire              reg_rd_i,
  output reg  [7:0]        reg_rdata_o,
  input  wire [7:0]        trig_sources_i,
  input  wire              global_irq_en_i,
  input  wire              irq_vector_ack_i,
  input  wire [RES_W-1:0]  core_result_i,
  output reg               irq_o,
  output reg               conv_irq_req_o,
  output reg               core_power_o,
  output reg               sample_start_o,
  output reg               conv_clk_en_o,
  output reg               busy_o
);

  // ----------------------------------------
  // Decode helper
  // ----------------------------------------
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg              power_q;
  reg              auto_q;
  reg              done_q;
  reg              done_d;
  reg              irq_en_q;
  reg [2:0]        div_q;
  reg [TRIG_W-1:0] trig_sel_q;
  reg [7:0]        mux_cfg_q;
  reg [1:0]        irq_mask_q;
  reg [1:0]        irq_stat_q;
  reg [RES_W-1:0]  result_q;
  reg              busy_q;
  reg              busy_d;
  reg              first_q;
  reg              first_d;
  reg [4:0]        cyc_q;
  reg [4:0]        cyc_d;
  reg [6:0]        pre_q;
  reg [6:0]        pre_d;
  reg [6:0]        pre_max;
  reg [7:0]        trig_q;
  reg              free_run_q;
  reg              free_run_d;
  reg [7:0]        rdata_d;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire             wr_ctrl;
  wire             wr_ctrl2;
  wire             wr_mux;
  wire             wr_mask;
  wire             rd_stat;
  wire             launch_wr;
  wire             power_next;
  wire             irq_en_next;
  wire             free_sel;

  assign wr_ctrl     = reg_wr_i & hit(reg_addr_i, `ADCCTL_OFS_CTRL);
  assign wr_ctrl2    = reg_wr_i & hit(reg_addr_i, `ADCCTL_OFS_CTRL2);
  assign wr_mux      = reg_wr_i & hit(reg_addr_i, `ADCCTL_OFS_MUXCFG);
  assign wr_mask     = reg_wr_i & hit(reg_addr_i, `ADCCTL_OFS_IRQ_MASK);
  assign rd_stat     = reg_rd_i & hit(reg_addr_i, `ADCCTL_OFS_IRQ_STAT);
  // Zero in the launch position never reaches the sequencer
  assign launch_wr   = wr_ctrl & reg_wdata_i[`ADCCTL_BIT_LAUNCH]; // [R1] [R5]
  assign power_next  = wr_ctrl ? reg_wdata_i[`ADCCTL_BIT_POWER] : power_q;
  assign irq_en_next = wr_ctrl ? reg_wdata_i[`ADCCTL_BIT_IRQ_EN] : irq_en_q;
  // Free-running is auto mode with trigger select zero
  assign free_sel    = (trig_sel_q == {TRIG_W{1'b0}});

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  function [6:0] pre_limit;
    input [2:0] code;
    begin
      case (code) // [R13]
        3'h0: begin
          pre_limit = `ADCCTL_PRE_MAX_2;
        end
        3'h1: begin
          pre_limit = `ADCCTL_PRE_MAX_2;
        end
        3'h2: begin
          pre_limit = `ADCCTL_PRE_MAX_4;
        end
        3'h3: begin
          pre_limit = `ADCCTL_PRE_MAX_8;
        end
        3'h4: begin
          pre_limit = `ADCCTL_PRE_MAX_16;
        end
        3'h5: begin
          pre_limit = `ADCCTL_PRE_MAX_32;
        end
        3'h6: begin
          pre_limit = `ADCCTL_PRE_MAX_64;
        end
        default: begin
          pre_limit = `ADCCTL_PRE_MAX_128;
        end
      endcase
    end
  endfunction

  always @* begin
    pre_max = pre_limit(div_q);
  end

  wire tick;
  assign tick = power_q & (pre_q >= pre_max); // [R13]

  // ----------------------------------------
  // Trigger edge
  // ----------------------------------------
  // Edges are found per source, so changing the select alone is no edge
  wire [7:0] trig_rise;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_edge
      assign trig_rise[gi] = trig_sources_i[gi] & ~trig_q[gi];
    end
  endgenerate

  wire trig_edge;
  assign trig_edge = auto_q & trig_rise[trig_sel_q]; // [R6] [R7]

  // ----------------------------------------
  // Conversion events
  // ----------------------------------------
  wire start;
  wire finish;
  wire restart;
  wire done_clr;

  // Launch while busy is dropped, not queued
  assign start    = power_next & ~busy_q & (launch_wr | trig_edge); // [R1] [R6]
  assign finish   = busy_q & tick & (cyc_q == 5'h01);
  assign restart  = finish & free_run_q & auto_q & free_sel & power_next; // [R2]
  assign done_clr = (wr_ctrl & reg_wdata_i[`ADCCTL_BIT_DONE]) | irq_vector_ack_i; // [R10] [R11]

  // ----------------------------------------
  // Prescaler next state
  // ----------------------------------------
  // Restarting at each start makes conversion length exact, at the cost of phase
  always @* begin
    if (!power_next || start || restart || tick) begin
      pre_d = 7'h00;
    end else begin
      pre_d = pre_q + 7'h01;
    end
  end

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always @* begin
    busy_d     = busy_q;
    first_d    = first_q;
    cyc_d      = cyc_q;
    free_run_d = free_run_q;
    if (!power_next) begin
      busy_d     = 1'b0; // [R17]
      first_d    = 1'b1;
      cyc_d      = 5'h00;
      free_run_d = 1'b0;
    end else if (start || restart) begin
      busy_d  = 1'b1; // [R1] [R2] [R6]
      first_d = 1'b0;
      if (first_q) begin
        cyc_d = `ADCCTL_CYC_FIRST; // [R3]
      end else begin
        cyc_d = `ADCCTL_CYC_NORMAL; // [R3]
      end
      if (launch_wr) begin
        free_run_d = reg_wdata_i[`ADCCTL_BIT_AUTO] & free_sel; // [R2]
      end
    end else if (finish) begin
      busy_d = 1'b0; // [R4]
    end else if (busy_q && tick) begin
      cyc_d = cyc_q - 5'h01;
    end
  end

  // ----------------------------------------
  // Done flag next state
  // ----------------------------------------
  always @* begin
    done_d = done_q;
    if (finish) begin
      done_d = 1'b1; // [R8]
    end else if (done_clr) begin
      done_d = 1'b0; // [R10] [R11]
    end
  end

  // ----------------------------------------
  // Interrupt status next state
  // ----------------------------------------
  wire [1:0] irq_event;
  wire [1:0] irq_stat_d;
  assign irq_event = {start | restart, finish};
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_stat
      // Set wins over the read clear so no event is lost
      assign irq_stat_d[gi] = irq_event[gi] | (irq_stat_q[gi] & ~rd_stat);
    end
  endgenerate

  // ----------------------------------------
  // Conversion state
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q     <= 1'b0;
      first_q    <= 1'b1;
      cyc_q      <= 5'h00;
      pre_q      <= 7'h00;
      trig_q     <= 8'h00;
      result_q   <= {RES_W{1'b0}};
      free_run_q <= 1'b0;
      done_q     <= 1'b0;
      irq_stat_q <= 2'h0;
    end else begin
      trig_q     <= trig_sources_i;
      pre_q      <= pre_d;
      busy_q     <= busy_d;
      first_q    <= first_d;
      cyc_q      <= cyc_d;
      free_run_q <= free_run_d;
      done_q     <= done_d;
      irq_stat_q <= irq_stat_d;
      if (finish) begin
        result_q <= core_result_i; // [R8]
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_q    <= 1'b0;
      auto_q     <= 1'b0;
      irq_en_q   <= 1'b0;
      div_q      <= 3'h0;
      trig_sel_q <= {TRIG_W{1'b0}};
      mux_cfg_q  <= `ADCCTL_RESET_VAL;
      irq_mask_q <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        power_q  <= reg_wdata_i[`ADCCTL_BIT_POWER]; // [R17]
        auto_q   <= reg_wdata_i[`ADCCTL_BIT_AUTO];
        irq_en_q <= reg_wdata_i[`ADCCTL_BIT_IRQ_EN];
        div_q    <= reg_wdata_i[2:0];
      end
      if (wr_ctrl2) begin
        trig_sel_q <= reg_wdata_i[TRIG_W-1:0]; // [R7]
      end
      if (wr_mux) begin
        mux_cfg_q <= reg_wdata_i;
      end
      if (wr_mask) begin
        irq_mask_q <= reg_wdata_i[1:0];
      end
    end
  end

  // ----------------------------------------
  // Result alignment
  // ----------------------------------------
  // Alignment acts on the stored code at once, also mid-conversion
  function [7:0] align_low;
    input       left;
    input [9:0] res;
    begin
      if (left) begin
        align_low = {res[1:0], 6'h00}; // [R16]
      end else begin
        align_low = res[7:0]; // [R14]
      end
    end
  endfunction

  function [7:0] align_high;
    input       left;
    input [9:0] res;
    begin
      if (left) begin
        align_high = res[9:2]; // [R15]
      end else begin
        align_high = {6'h00, res[9:8]}; // [R14]
      end
    end
  endfunction

  wire       left;
  wire [7:0] res_lo;
  wire [7:0] res_hi;
  assign left   = mux_cfg_q[`ADCCTL_BIT_LEFT];
  assign res_lo = align_low(left, result_q[9:0]);
  assign res_hi = align_high(left, result_q[9:0]);

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    case (reg_addr_i)
      `ADCCTL_OFS_RES_LOW: begin
        rdata_d = res_lo;
      end
      `ADCCTL_OFS_RES_HIGH: begin
        rdata_d = res_hi;
      end
      `ADCCTL_OFS_CTRL: begin
        rdata_d = {power_q, busy_q, auto_q, done_q, irq_en_q, div_q}; // [R4]
      end
      `ADCCTL_OFS_CTRL2: begin
        rdata_d = {{(8-TRIG_W){1'b0}}, trig_sel_q};
      end
      `ADCCTL_OFS_MUXCFG: begin
        rdata_d = mux_cfg_q;
      end
      `ADCCTL_OFS_IRQ_MASK: begin
        rdata_d = {6'h00, irq_mask_q};
      end
      `ADCCTL_OFS_IRQ_STAT: begin
        rdata_d = {6'h00, irq_stat_q};
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // All outputs are flops; busy_o, core_power_o and conv_irq_req_o take next-state values, while conv_clk_en_o lags tick by one cycle
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o    <= 8'h00;
      irq_o          <= 1'b0;
      conv_irq_req_o <= 1'b0;
      core_power_o   <= 1'b0;
      sample_start_o <= 1'b0;
      conv_clk_en_o  <= 1'b0;
      busy_o         <= 1'b0;
    end else begin
      reg_rdata_o    <= reg_rd_i ? rdata_d : 8'h00;
      conv_irq_req_o <= done_d & irq_en_next & global_irq_en_i; // [R9]
      irq_o          <= |(irq_mask_q & irq_stat_d);
      core_power_o   <= power_next;
      sample_start_o <= start | restart; // [R1] [R2]
      conv_clk_en_o  <= tick;
      busy_o         <= busy_d; // [R4]
    end
  end

endmodule

//--- verif/adcctl_core_model.sv
// Analog core stand-in: a fresh code per start.
// Assumes one start pulse per conversion.
`timescale 1ns/1ps
module adcctl_core_model (
  input  wire       clk_i,
  input  wire       power_i,
  input  wire       start_i,
  output wire [9:0] code_o
);
  reg [9:0] code_q = 10'h2C5;
  always @(posedge clk_i) begin
    if (start_i) code_q <= code_q + 10'h0B7;
  end
  // Junk when unpowered, so stale codes show
  assign code_o = power_i ? code_q : ~code_q;
endmodule

//--- verif/adcctl_chk_chk.sv
// Port checks of the converter control block.
// Assumes one clock domain; bound to adcctl_top.
`timescale 1ns/1ps
module adcctl_chk (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire global_irq_en_i,
  input wire irq_o,
  input wire conv_irq_req_o,
  input wire core_power_o,
  input wire sample_start_o,
  input wire conv_clk_en_o,
  input wire busy_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  AST_REQ_GIE: assert property (conv_irq_req_o |-> $past(global_irq_en_i))
    else $error("req without gie");
  AST_START_BUSY: assert property (sample_start_o |-> busy_o)
    else $error("start not busy");
  AST_START_PWR: assert property (sample_start_o |-> core_power_o)
    else $error("start unpowered");
  AST_START_ONE: assert property (sample_start_o |=> !sample_start_o)
    else $error("start too long");
  AST_BUSY_CAUSE: assert property ($rose(busy_o) |-> sample_start_o)
    else $error("busy w/o start");
  AST_BUSY_MIN: assert property ($rose(busy_o) |-> busy_o[*8] or ##[1:8] !core_power_o)
    else $error("conversion short");
  AST_CLK_PULSE: assert property (conv_clk_en_o |=> !conv_clk_en_o)
    else $error("clock pulse long");
  AST_OFF_IDLE: assert property (!core_power_o && !$past(core_power_o) |-> !busy_o && !conv_clk_en_o)
    else $error("busy while off");
  C_START: cover property (sample_start_o);
  C_REQ: cover property (conv_irq_req_o);
  C_IRQ: cover property (irq_o);
endmodule
bind adcctl_top adcctl_chk u_chk (.clk_sys_i, .rst_n_i, .global_irq_en_i, .irq_o, .conv_irq_req_o,
  .core_power_o, .sample_start_o, .conv_clk_en_o, .busy_o);

//--- verif/test_adc_control_and_result.sv
// Bench for the converter control block.
// Assumes the core model and a 40 MHz clock.
`timescale 1ns/1ps
module test_adc_control_and_result;
  reg        clk_sys_i = 1'b0;
  reg        rst_n_i = 1'b0;
  reg  [7:0] reg_addr_i = 8'h00;
  reg  [7:0] reg_wdata_i = 8'h00;
  reg        reg_wr_i = 1'b0;
  reg        reg_rd_i = 1'b0;
  reg  [7:0] trig_sources_i = 8'h00;
  reg        global_irq_en_i = 1'b0;
  reg        irq_vector_ack_i = 1'b0;
  wire [7:0] reg_rdata_o;
  wire [9:0] core_result_i;
  wire       irq_o, conv_irq_req_o, core_power_o, sample_start_o, conv_clk_en_o, busy_o;
  reg  [7:0] rv;
  reg  [9:0] res;
  integer    errors = 0;
  integer    n_compared = 0;
  integer    n;
  always #12.5 clk_sys_i = ~clk_sys_i;
  adcctl_top dut (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .trig_sources_i, .global_irq_en_i, .irq_vector_ack_i, .core_result_i, .irq_o, .conv_irq_req_o,
    .core_power_o, .sample_start_o, .conv_clk_en_o, .busy_o);
  adcctl_core_model u_core (.clk_i(clk_sys_i), .power_i(core_power_o), .start_i(sample_start_o),
    .code_o(core_result_i));
  task chk(input string nm, input [9:0] e, input [9:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("BAD %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 rv = reg_rdata_o;
    end
  endtask
  task settle;
    begin
      repeat (2) @(posedge clk_sys_i);
      #1;
    end
  endtask
  // Counts busy cycles from the edge that starts the conversion
  task run(input integer e);
    begin
      #1 n = 0;
      while (busy_o === 1'b1 && n < 9000) begin
        @(posedge clk_sys_i);
        #1 n = n + 1;
      end
      res = core_result_i;
      if (e != 0) chk("length", e, n);
    end
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  task t_first;
    begin
      rd(8'h79);
      chk("high rst", 10'h000, rv);
      wr(8'h7A, 8'hC0);
      run(50);
      rd(8'h7A);
      chk("done", 10'h001, rv[4]);
      chk("launch", 10'h000, rv[6]);
      rd(8'h78);
      chk("low r", res[7:0], rv);
      rd(8'h79);
      chk("high r", res[9:8], rv);
      rd(8'h40);
      chk("unmapped", 10'h000, rv);
      wr(8'h7C, 8'h20);
      rd(8'h79);
      chk("high l", res[9:2], rv);
      rd(8'h78);
      chk("low l", {res[1:0], 6'h00}, rv);
      $display("first done");
    end
  endtask
  task t_div;
    integer c;
    begin
      for (c = 0; c < 8; c = c + 1) begin
        wr(8'h7A, 8'hC0 | c[7:0]);
        run(13 * ((c < 2) ? 2 : (1 << c)));
      end
      $display("divider done");
    end
  endtask
  task t_zero;
    begin
      wr(8'h7A, 8'hC0);
      rd(8'h7A);
      chk("launch", 10'h001, rv[6]);
      wr(8'h7A, 8'h80);
      #1 chk("zero write", 10'h001, busy_o);
      wr(8'h7A, 8'h00);
      #1 chk("power off", 10'h000, busy_o);
      $display("zero done");
    end
  endtask
  task t_irq;
    begin
      wr(8'h7D, 8'h01);
      wr(8'h7A, 8'hC8);
      run(50);
      settle;
      chk("req gie0", 10'h000, conv_irq_req_o);
      @(posedge clk_sys_i) global_irq_en_i <= 1'b1;
      settle;
      chk("req", 10'h001, conv_irq_req_o);
      chk("irq", 10'h001, irq_o);
      rd(8'h7E);
      chk("status", 10'h001, rv[0]);
      settle;
      chk("irq read", 10'h000, irq_o);
      @(posedge clk_sys_i) irq_vector_ack_i <= 1'b1;
      @(posedge clk_sys_i);
      irq_vector_ack_i <= 1'b0;
      settle;
      chk("req ack", 10'h000, conv_irq_req_o);
      wr(8'h7A, 8'hC8);
      run(26);
      wr(8'h7A, 8'h88);
      settle;
      chk("req w0", 10'h001, conv_irq_req_o);
      wr(8'h7A, 8'h98);
      settle;
      chk("req w1", 10'h000, conv_irq_req_o);
      $display("irq done");
    end
  endtask
  task t_trig;
    begin
      wr(8'h7B, 8'h03);
      wr(8'h7A, 8'hA0);
      @(posedge clk_sys_i) trig_sources_i <= 8'h04;
      settle;
      chk("other src", 10'h000, busy_o);
      @(posedge clk_sys_i) trig_sources_i <= 8'h0C;
      @(posedge clk_sys_i);
      #1 chk("trig edge", 10'h001, busy_o);
      run(26);
      $display("trigger done");
    end
  endtask
  task t_free;
    integer k;
    begin
      wr(8'h7B, 8'h00);
      wr(8'h7A, 8'hE0);
      n = 0;
      for (k = 0; k < 80; k = k + 1) begin
        @(posedge clk_sys_i);
        #1 if (sample_start_o === 1'b1) n = n + 1;
      end
      chk("free starts", 10'h003, n[9:0]);
      rd(8'h7A);
      chk("free busy", 10'h001, rv[6]);
      wr(8'h7A, 8'h00);
      $display("free done");
    end
  endtask
  task end_sim;
    begin
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_first;
    t_div;
    t_zero;
    t_irq;
    t_trig;
    t_free;
    end_sim;
  end
  initial begin
    #(25 * 20000);
    errors = errors + 1;
    end_sim;
  end
endmodule
